/* rtl/reclocker_ctrl.sv */
// control logic of the serial video reclocker: mode, pin reuse, muxes, drivers, status
`timescale 1ns/100ps

// What this block does
// - mode pin 0 pins, 1 registers
// - register mode turns control pins into port
// - select pins keep role until reassigned
// - general io role survives return to pins
// - inputs equalized separately, each with detect
// - extra equalizer gain bit
// - per-input signal present readable
// - active input signal present readable
// - three-bit detect threshold field
// - select pins pick input, default input 0
// - override bit hands choice to register
// - secondary mux follows primary unless overridden
// - secondary taken before or after equalizer
// - output sources: reclocked, bypassed, clock
// - per-output swing, default 800 mV
// - shared common offset, default 1.2 V
// - per-output de-emphasis, default off
// - polarity flip inverts both drivers
// - each driver powers down independently
// - lock on pin and register, never bypassed
// - mute beats bypass on both outputs
// - clock output muted on bypass or unlock
module reclocker_ctrl
   import reclocker_ctrl_pkg::*;
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // mode select pin
   input wire logic modeSelect,
   // dual role pins: bypass/mosi, mute_n/sck, clock_out_select/ss_n
   input wire logic bypassMosiPin,
   input wire logic muteNSckPin,
   input wire logic clockOutSsNPin,
   // dual role ground/miso pin
   output logic misoOut,
   output logic misoOe,
   // input select pins
   input wire logic input_pick_high,
   input wire logic input_pick_low,
   // analog status
   input wire logic [3:0] per_input_signal_present,
   input wire logic cdrLock,
   // equalizer and mux controls
   output logic extra_eq_gain,
   output logic [2:0] detect_threshold,
   output logic [1:0] activeChannel,
   output logic [1:0] secondaryChannel,
   output logic secondary_pre_post_eq,
   // output source steering
   output out_a_src_e outASource,
   output out_b_src_e outBSource,
   // driver settings
   output logic [1:0] swing_a,
   output logic [1:0] swing_b,
   output logic [1:0] common_offset,
   output logic [1:0] deemph_a,
   output logic [1:0] deemph_b,
   output logic polarity_flip,
   output logic driver_a_off,
   output logic driver_b_off,
   // status and pin roles
   output logic locked_flag,
   output logic registerMode,
   output logic pinsAsGeneralIo
);
`include "reclocker_ctrl_map.svh"

   // positions inside the synchronised input vector
   localparam int S_SIG = 0;
   localparam int S_LOCK = 4;
   localparam int S_PICK_LO = 5;
   localparam int S_PICK_HI = 6;
   localparam int S_MODE = 7;
   localparam int S_P15 = 8;
   localparam int S_P16 = 9;
   localparam int S_P37 = 10;

   ctrl_s q_r;
   ctrl_s q_nxt;
   logic [10:0] asyncIn;
   logic spiMode;
   logic [6:0] regAddr;
   logic wrEn;
   logic [7:0] wrData;
   logic [7:0] rdData;
   logic [3:0] sigNow;
   logic lockNow;
   logic muteN;
   logic bypass;
   logic clockOut;
   logic locked;
   logic [1:0] primary;
   logic activeSig;

   assign asyncIn = {clockOutSsNPin, muteNSckPin, bypassMosiPin, modeSelect,
                     input_pick_high, input_pick_low, cdrLock, per_input_signal_present};

   // filtered levels
   assign spiMode = q_r.stable[S_MODE];
   assign sigNow = q_r.stable[S_SIG +: 4];
   assign lockNow = q_r.stable[S_LOCK];

   // mute, bypass and clock output from pins or register by mode
   assign muteN = spiMode ? q_r.reg12[`BIT_MUTE_CTRL_N] : q_r.stable[S_P16];
   assign bypass = spiMode ? q_r.reg12[`BIT_BYPASS_CTRL] : q_r.stable[S_P15];
   assign clockOut = spiMode ? q_r.reg12[`BIT_CLOCK_OUT_SELECT] : q_r.stable[S_P37];
   assign locked = lockNow & ~bypass;

   // primary choice: pins until the override is set in register mode
   assign primary = (spiMode && q_r.reg1E[`BIT_INPUT_OVERRIDE]) ?
                    q_r.reg20[`LSB_REGISTER_CHOICE +: 2] :
                    {q_r.stable[S_PICK_HI], q_r.stable[S_PICK_LO]};
   assign activeSig = sigNow[primary];

   // the dual-role pins feed the register port only in register mode
   reg_serial_port u_port (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .portEnable(spiMode),
      .mosi(q_r.stable[S_P15]),
      .sck(q_r.stable[S_P16]),
      .ssN(q_r.stable[S_P37]),
      .regAddr(regAddr),
      .wrEn(wrEn),
      .wrData(wrData),
      .rdData(rdData),
      .misoOut(misoOut),
      .misoOe(misoOe)
   );

   // read mux; unmapped addresses read as zero
   always_comb begin
      case (regAddr)
         `OFS_DETECT_LOCK_STATUS: rdData = {3'h0, locked, sigNow};
         `OFS_ACTIVE_INPUT_STATUS: rdData = {3'h0, activeSig, 4'h0};
         `OFS_EQ_DRIVER_COMMON: rdData = q_r.reg11;
         `OFS_OUTPUT_SWING: rdData = q_r.reg12;
         `OFS_OUTPUT_DEEMPH: rdData = q_r.reg13;
         `OFS_SECONDARY_MUX: rdData = q_r.reg14;
         `OFS_SECONDARY_SELECT: rdData = q_r.reg18;
         `OFS_INPUT_OVERRIDE: rdData = q_r.reg1E;
         `OFS_GENERAL_IO_ROLE: rdData = q_r.reg1F;
         `OFS_DETECT_LEVEL_CHAN: rdData = q_r.reg20;
         default: rdData = 8'h00;
      endcase
   end

   // next state of synchronisers, registers and registered outputs
   always_comb begin
      q_nxt = q_r;
      // three stages; a level is taken once stages two and three agree
      q_nxt.sync1 = asyncIn;
      q_nxt.sync2 = q_r.sync1;
      q_nxt.sync3 = q_r.sync2;
      q_nxt.stable = (q_r.sync2 & ~(q_r.sync2 ^ q_r.sync3)) |
                     (q_r.stable & (q_r.sync2 ^ q_r.sync3));

      // register writes; the port only runs in register mode
      if (wrEn) begin
         case (regAddr)
            `OFS_EQ_DRIVER_COMMON: q_nxt.reg11 = wrData;
            `OFS_OUTPUT_SWING: q_nxt.reg12 = wrData;
            `OFS_OUTPUT_DEEMPH: q_nxt.reg13 = wrData;
            `OFS_SECONDARY_MUX: q_nxt.reg14 = wrData;
            `OFS_SECONDARY_SELECT: q_nxt.reg18 = wrData;
            `OFS_INPUT_OVERRIDE: q_nxt.reg1E = wrData;
            `OFS_GENERAL_IO_ROLE: q_nxt.reg1F = wrData;
            `OFS_DETECT_LEVEL_CHAN: q_nxt.reg20 = wrData;
            default: q_nxt.reg11 = q_r.reg11;
         endcase
      end

      // equalizer and detector controls
      q_nxt.extraEqGain = q_r.reg11[`BIT_EXTRA_EQ_GAIN];
      q_nxt.detectThreshold = q_r.reg20[`LSB_DETECT_THRESHOLD +: 3];

      // input muxes
      q_nxt.activeChannel = primary;
      q_nxt.secondaryChannel = q_r.reg14[`BIT_SECONDARY_OVERRIDE] ?
                               q_r.reg18[`LSB_SECONDARY_CHOICE +: 2] : primary;
      q_nxt.secondaryPrePostEq = q_r.reg14[`BIT_SECONDARY_PRE_EQ];

      // output steering; mute first, then lock decides reclocked or bypassed
      if (!muteN) begin
         q_nxt.outASource = A_MUTED;
         q_nxt.outBSource = B_MUTED;
      end else begin
         q_nxt.outASource = locked ? A_RECLOCKED : A_BYPASSED;
         if (clockOut) begin
            q_nxt.outBSource = locked ? B_CLOCK : B_MUTED;
         end else begin
            q_nxt.outBSource = locked ? B_RECLOCKED : B_BYPASSED;
         end
      end

      // driver settings
      q_nxt.swingA = q_r.reg12[`LSB_SWING_A +: 2];
      q_nxt.swingB = q_r.reg12[`LSB_SWING_B +: 2];
      q_nxt.commonOffset = q_r.reg11[`LSB_COMMON_OFFSET +: 2];
      q_nxt.deemphA = q_r.reg13[`LSB_DEEMPH_A +: 2];
      q_nxt.deemphB = q_r.reg13[`LSB_DEEMPH_B +: 2];
      q_nxt.polarityFlip = q_r.reg11[`BIT_POLARITY_FLIP];
      q_nxt.driverAOff = q_r.reg11[`BIT_DRIVER_A_OFF];
      q_nxt.driverBOff = q_r.reg11[`BIT_DRIVER_B_OFF];

      // status and pin roles; the role bit is kept across mode changes
      q_nxt.lockedPin = locked;
      q_nxt.registerMode = spiMode;
      q_nxt.pinsAsGeneralIo = q_r.reg1F[`BIT_GENERAL_IO_ROLE];
   end

   // all state in one register, frozen while ce is low
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q_r <= '0;
         q_r.reg11 <= `RST_EQ_DRIVER_COMMON;
         q_r.reg12 <= `RST_OUTPUT_SWING;
         q_r.reg13 <= `RST_OUTPUT_DEEMPH;
         q_r.reg14 <= `RST_SECONDARY_MUX;
         q_r.reg18 <= `RST_SECONDARY_SELECT;
         q_r.reg1E <= `RST_INPUT_OVERRIDE;
         q_r.reg1F <= `RST_GENERAL_IO_ROLE;
         q_r.reg20 <= `RST_DETECT_LEVEL_CHAN;
         q_r.swingA <= 2'h3;
         q_r.swingB <= 2'h3;
         q_r.outASource <= A_MUTED;
         q_r.outBSource <= B_MUTED;
      end else if (ce) begin
         q_r <= q_nxt;
      end
   end

   // outputs straight from the state register
   assign extra_eq_gain = q_r.extraEqGain;
   assign detect_threshold = q_r.detectThreshold;
   assign activeChannel = q_r.activeChannel;
   assign secondaryChannel = q_r.secondaryChannel;
   assign secondary_pre_post_eq = q_r.secondaryPrePostEq;
   assign outASource = q_r.outASource;
   assign outBSource = q_r.outBSource;
   assign swing_a = q_r.swingA;
   assign swing_b = q_r.swingB;
   assign common_offset = q_r.commonOffset;
   assign deemph_a = q_r.deemphA;
   assign deemph_b = q_r.deemphB;
   assign polarity_flip = q_r.polarityFlip;
   assign driver_a_off = q_r.driverAOff;
   assign driver_b_off = q_r.driverBOff;
   assign locked_flag = q_r.lockedPin;
   assign registerMode = q_r.registerMode;
   assign pinsAsGeneralIo = q_r.pinsAsGeneralIo;

endmodule

/* rtl/reclocker_ctrl_map.svh */
// register offsets, field positions and reset values of the reclocker control block
`ifndef RECLOCKER_CTRL_MAP_SVH
`define RECLOCKER_CTRL_MAP_SVH

// register offsets (7-bit register address)
`define OFS_DETECT_LOCK_STATUS 7'h01
`define OFS_ACTIVE_INPUT_STATUS 7'h03
`define OFS_EQ_DRIVER_COMMON 7'h11
`define OFS_OUTPUT_SWING 7'h12
`define OFS_OUTPUT_DEEMPH 7'h13
`define OFS_SECONDARY_MUX 7'h14
`define OFS_SECONDARY_SELECT 7'h18
`define OFS_INPUT_OVERRIDE 7'h1E
`define OFS_GENERAL_IO_ROLE 7'h1F
`define OFS_DETECT_LEVEL_CHAN 7'h20

// field positions
`define BIT_LOCKED_FLAG 4
`define BIT_ACTIVE_SIGNAL 4
`define BIT_EXTRA_EQ_GAIN 1
`define BIT_POLARITY_FLIP 0
`define BIT_DRIVER_A_OFF 4
`define BIT_DRIVER_B_OFF 3
`define LSB_COMMON_OFFSET 6
`define LSB_SWING_A 6
`define LSB_SWING_B 4
`define LSB_DEEMPH_A 6
`define LSB_DEEMPH_B 4
`define BIT_BYPASS_CTRL 2
`define BIT_MUTE_CTRL_N 1
`define BIT_CLOCK_OUT_SELECT 0
`define BIT_SECONDARY_OVERRIDE 5
`define BIT_SECONDARY_PRE_EQ 1
`define LSB_SECONDARY_CHOICE 0
`define BIT_INPUT_OVERRIDE 7
`define BIT_GENERAL_IO_ROLE 0
`define LSB_DETECT_THRESHOLD 3
`define LSB_REGISTER_CHOICE 1

// reset values
`define RST_EQ_DRIVER_COMMON 8'h00
`define RST_OUTPUT_SWING 8'hF2
`define RST_OUTPUT_DEEMPH 8'h00
`define RST_SECONDARY_MUX 8'h00
`define RST_SECONDARY_SELECT 8'h00
`define RST_INPUT_OVERRIDE 8'h00
`define RST_GENERAL_IO_ROLE 8'h00
`define RST_DETECT_LEVEL_CHAN 8'h00

`endif

/* rtl/reclocker_ctrl_pkg.sv */
// types shared by the reclocker control block
package reclocker_ctrl_pkg;

   // source of the first output driver
   typedef enum logic [1:0] {
      A_RECLOCKED = 2'h0,
      A_BYPASSED = 2'h1,
      A_MUTED = 2'h3
   } out_a_src_e;

   // source of the second output driver
   typedef enum logic [1:0] {
      B_RECLOCKED = 2'h0,
      B_BYPASSED = 2'h1,
      B_MUTED = 2'h3,
      B_CLOCK = 2'h2
   } out_b_src_e;

   // serial register port frame states
   typedef enum logic [1:0] {
      SP_IDLE = 2'h0,
      SP_ADDR = 2'h1,
      SP_DATA = 2'h3
   } spi_state_e;

   typedef struct packed {
      spi_state_e st;
      logic [2:0] bitCnt;
      logic [7:0] shiftIn;
      logic [6:0] addr;
      logic isRead;
      logic loadRd;
      logic [7:0] shiftOut;
      logic sckPrev;
      logic wrEn;
      logic [7:0] wrData;
      logic misoOut;
      logic misoOe;
   } spi_s;

   typedef struct packed {
      logic [10:0] sync1;
      logic [10:0] sync2;
      logic [10:0] sync3;
      logic [10:0] stable;
      logic [7:0] reg11;
      logic [7:0] reg12;
      logic [7:0] reg13;
      logic [7:0] reg14;
      logic [7:0] reg18;
      logic [7:0] reg1E;
      logic [7:0] reg1F;
      logic [7:0] reg20;
      logic extraEqGain;
      logic [2:0] detectThreshold;
      logic [1:0] activeChannel;
      logic [1:0] secondaryChannel;
      logic secondaryPrePostEq;
      out_a_src_e outASource;
      out_b_src_e outBSource;
      logic [1:0] swingA;
      logic [1:0] swingB;
      logic [1:0] commonOffset;
      logic [1:0] deemphA;
      logic [1:0] deemphB;
      logic polarityFlip;
      logic driverAOff;
      logic driverBOff;
      logic lockedPin;
      logic registerMode;
      logic pinsAsGeneralIo;
   } ctrl_s;

endpackage

/* rtl/reg_serial_port.sv */
// serial register port: 8-bit command byte then 8-bit data byte, sampled on clk
`timescale 1ns/100ps
module reg_serial_port
   import reclocker_ctrl_pkg::*;
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // port active only in register mode
   input wire logic portEnable,
   // filtered pin levels
   input wire logic mosi,
   input wire logic sck,
   input wire logic ssN,
   // register file side
   output logic [6:0] regAddr,
   output logic wrEn,
   output logic [7:0] wrData,
   input wire logic [7:0] rdData,
   // read data pin
   output logic misoOut,
   output logic misoOe
);
`include "reclocker_ctrl_map.svh"

   spi_s q_r;
   spi_s q_nxt;
   logic rise;
   logic fall;

   assign rise = sck & ~q_r.sckPrev;
   assign fall = ~sck & q_r.sckPrev;

   // frame sequencing: sample on rising sck, shift read data on falling sck
   always_comb begin
      q_nxt = q_r;
      q_nxt.wrEn = 1'b0;
      q_nxt.sckPrev = sck;
      if (!portEnable || ssN) begin
         // deselect aborts a half frame; nothing is written
         q_nxt.st = SP_IDLE;
         q_nxt.bitCnt = 3'h0;
         q_nxt.loadRd = 1'b0;
         q_nxt.misoOe = 1'b0;
         q_nxt.misoOut = 1'b0;
      end else begin
         q_nxt.misoOe = 1'b1;
         if (q_r.loadRd) begin
            // read data comes one cycle after the address settles
            q_nxt.loadRd = 1'b0;
            q_nxt.shiftOut = rdData;
            q_nxt.misoOut = rdData[7];
         end
         case (q_r.st)
            SP_IDLE: begin
               q_nxt.st = SP_ADDR;
            end
            SP_ADDR: begin
               if (rise) begin
                  q_nxt.shiftIn = {q_r.shiftIn[6:0], mosi};
                  q_nxt.bitCnt = q_r.bitCnt + 3'h1;
                  if (q_r.bitCnt == 3'h7) begin
                     q_nxt.isRead = q_r.shiftIn[6];
                     q_nxt.addr = {q_r.shiftIn[5:0], mosi};
                     q_nxt.loadRd = q_r.shiftIn[6];
                     q_nxt.st = SP_DATA;
                  end
               end
            end
            SP_DATA: begin
               if (rise) begin
                  q_nxt.shiftIn = {q_r.shiftIn[6:0], mosi};
                  q_nxt.bitCnt = q_r.bitCnt + 3'h1;
                  if (q_r.bitCnt == 3'h7) begin
                     q_nxt.wrEn = ~q_r.isRead;
                     q_nxt.wrData = {q_r.shiftIn[6:0], mosi};
                     q_nxt.st = SP_ADDR;
                  end
               end else if (fall && q_r.isRead && q_r.bitCnt != 3'h0) begin
                  q_nxt.shiftOut = {q_r.shiftOut[6:0], 1'b0};
                  q_nxt.misoOut = q_r.shiftOut[6];
               end
            end
            default: begin
               q_nxt.st = SP_IDLE;
            end
         endcase
      end
   end

   // state register, frozen while ce is low
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q_r <= '0;
      end else if (ce) begin
         q_r <= q_nxt;
      end
   end

   assign regAddr = q_r.addr;
   assign wrEn = q_r.wrEn;
   assign wrData = q_r.wrData;
   assign misoOut = q_r.misoOut;
   assign misoOe = q_r.misoOe;

endmodule

/* verif/reclocker_ctrl_monitor.sv */
// concurrent checks on the ports of the reclocker control block
`timescale 1ns/100ps
module reclocker_ctrl_monitor
   import reclocker_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // watched inputs
   input wire logic modeSelect,
   input wire logic clockOutSsNPin,
   input wire logic input_pick_high,
   input wire logic input_pick_low,
   input wire logic cdrLock,
   // watched outputs
   input wire logic misoOe,
   input wire logic [1:0] activeChannel,
   input out_a_src_e outASource,
   input out_b_src_e outBSource,
   input wire logic locked_flag,
   input wire logic registerMode,
   input wire logic pinsAsGeneralIo
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // select pins held long enough in pin mode; slack covers the 3-flop filter
   sequence s_pins_settled;
      (!registerMode && !pinsAsGeneralIo && $stable({input_pick_high, input_pick_low}))[*8];
   endsequence

   // select line released and left high
   sequence s_select_released;
      $rose(clockOutSsNPin) ##1 clockOutSsNPin[*5];
   endsequence

   a_mode_to_regs: assert property (modeSelect[*8] |-> registerMode)
      else $error("register mode not entered");
   a_mode_to_pins: assert property (!modeSelect[*8] |-> !registerMode)
      else $error("pin mode not entered");
   a_miso_pin_mode: assert property (!registerMode && !$past(registerMode) |-> !misoOe)
      else $error("read data driven in pin mode");
   a_miso_released: assert property (s_select_released |-> !misoOe)
      else $error("read data driven after select release");
   a_pin_choice: assert property (s_pins_settled |-> activeChannel == {input_pick_high, input_pick_low})
      else $error("active input differs from select pins");
   a_lock_no_bypass: assert property (locked_flag |-> outASource != A_BYPASSED)
      else $error("lock shown while bypassed");
   a_lock_from_cdr: assert property ($rose(locked_flag) |-> $past(cdrLock, 4) && $past(cdrLock, 5))
      else $error("lock rose without recovered lock");
   a_reclocked_locked: assert property (outASource == A_RECLOCKED |-> locked_flag)
      else $error("reclocked data without lock");
   a_mute_both: assert property (outASource == A_MUTED |-> outBSource == B_MUTED)
      else $error("mute did not cover both outputs");
   a_clock_needs_lock: assert property (outBSource == B_CLOCK |-> locked_flag && outASource == A_RECLOCKED)
      else $error("clock output without lock");
endmodule

bind reclocker_ctrl reclocker_ctrl_monitor u_monitor (.clk, .reset, .modeSelect, .clockOutSsNPin,
   .input_pick_high, .input_pick_low, .cdrLock, .misoOe, .activeChannel, .outASource, .outBSource,
   .locked_flag, .registerMode, .pinsAsGeneralIo);

/* verif/spi_host_model.sv */
// host controller model for the serial register port
`timescale 1ns/100ps
module spi_host_model (
   // clock
   input wire logic clk,
   // serial pins
   output logic mosi,
   output logic sck,
   output logic ssN,
   input wire logic misoOut,
   input wire logic misoOe
);
   // idle: clock stands still, select high
   initial begin
      mosi = 1'b0;
      sck = 1'b0;
      ssN = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // one 16-bit frame, mode 0, msb first, 160 ns clock; undriven read bits come back unknown
   task automatic xfer(input logic [15:0] frame, output logic [7:0] rdData);
      rdData = 8'h00;
      ssN = 1'b0;
      wait_clk(8);
      for (int i = 15; i >= 0; i--) begin
         mosi = frame[i];
         wait_clk(8);
         sck = 1'b1;
         if (i < 8) rdData[i] = misoOe ? misoOut : 1'bx;
         wait_clk(8);
         sck = 1'b0;
      end
      wait_clk(8);
      ssN = 1'b1;
      mosi = ~mosi; // released data line must not keep its last value
      wait_clk(16);
   endtask
endmodule

/* verif/reclocker_ctrl_tb.sv */
// self-checking bench for the reclocker control block
`timescale 1ns/100ps
`include "reclocker_ctrl_map.svh"
module reclocker_ctrl_tb;
   import reclocker_ctrl_pkg::*;
   logic clk = 1'b0, reset = 1'b1, ce = 1'b1, modeSelect = 1'b0;
   logic pinByp = 1'b0, pinMuteN = 1'b1, pinSco = 1'b0, pickHigh = 1'b0, pickLow = 1'b0;
   logic cdrLock = 1'b0;
   logic [3:0] sigPresent = 4'h0;
   logic mosi, sck, ssN, misoOut, misoOe, bypassMosiPin, muteNSckPin, clockOutSsNPin;
   logic extra_eq_gain, secondary_pre_post_eq, polarity_flip, driver_a_off, driver_b_off;
   logic locked_flag, registerMode, pinsAsGeneralIo;
   logic [2:0] detect_threshold;
   logic [1:0] activeChannel, secondaryChannel, swing_a, swing_b, common_offset, deemph_a, deemph_b;
   out_a_src_e outASource;
   out_b_src_e outBSource;
   int failures = 0, compares = 0, cycles = 0;

   // shared pins follow the mode: host port in register mode, strap levels otherwise
   assign bypassMosiPin = modeSelect ? mosi : pinByp;
   assign muteNSckPin = modeSelect ? sck : pinMuteN;
   assign clockOutSsNPin = modeSelect ? ssN : pinSco;

   always #5 clk = ~clk;

   reclocker_ctrl u_dut (.clk, .reset, .ce, .modeSelect, .bypassMosiPin, .muteNSckPin,
      .clockOutSsNPin, .misoOut, .misoOe, .input_pick_high(pickHigh), .input_pick_low(pickLow),
      .per_input_signal_present(sigPresent), .cdrLock, .extra_eq_gain, .detect_threshold,
      .activeChannel, .secondaryChannel, .secondary_pre_post_eq, .outASource, .outBSource,
      .swing_a, .swing_b, .common_offset, .deemph_a, .deemph_b, .polarity_flip, .driver_a_off,
      .driver_b_off, .locked_flag, .registerMode, .pinsAsGeneralIo);

   spi_host_model u_host (.clk, .mosi, .sck, .ssN, .misoOut, .misoOe);

   task automatic print_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // a hang ends the run as a failure
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] junk;
      u_host.xfer({1'b0, a, d}, junk);
   endtask

   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      u_host.xfer({1'b1, a, 8'h00}, d);
   endtask

   task automatic t_reset();
      tick(8);
      check(swing_a, 2'h3, "swing a");
      check(swing_b, 2'h3, "swing b");
      check(common_offset, 2'h0, "offset");
      check({deemph_a, deemph_b}, 4'h0, "deemphasis");
      check({polarity_flip, driver_a_off, driver_b_off}, 3'h0, "driver bits");
      check({extra_eq_gain, secondary_pre_post_eq, detect_threshold}, 5'h00, "eq bits");
      check(registerMode, 1'h0, "mode");
      check({activeChannel, secondaryChannel}, 4'h0, "channels");
      check(misoOe, 1'h0, "read pin idle");
      $display("test reset done");
   endtask

   task automatic t_pick();
      for (int k = 0; k < 4; k++) begin
         {pickHigh, pickLow} = k[1:0];
         tick(8);
         check(activeChannel, k[1:0], "pin choice");
         check(secondaryChannel, k[1:0], "secondary follows");
      end
      $display("test pick done");
   endtask

   // every strap combination against the output steering table
   task automatic t_outputs();
      logic locked;
      logic [1:0] expA, expB;
      for (int k = 0; k < 16; k++) begin
         {pinMuteN, pinByp, pinSco, cdrLock} = k[3:0];
         tick(8);
         locked = cdrLock & ~pinByp;
         expA = !pinMuteN ? 2'h3 : (locked ? 2'h0 : 2'h1);
         expB = !pinMuteN ? 2'h3 : (pinSco ? (locked ? 2'h2 : 2'h3) : expA);
         check(outASource, expA, "source a");
         check(outBSource, expB, "source b");
         check(locked_flag, locked, "lock");
      end
      {pinMuteN, pinByp, pinSco, cdrLock} = 4'h8;
      $display("test outputs done");
   endtask

   task automatic t_regs();
      logic [7:0] d;
      {pickHigh, pickLow} = 2'h1;
      modeSelect = 1'b1;
      tick(10);
      check(registerMode, 1'h1, "mode");
      wr(`OFS_EQ_DRIVER_COMMON, 8'h9B);
      wr(`OFS_OUTPUT_SWING, 8'h62);
      wr(`OFS_OUTPUT_DEEMPH, 8'hB0);
      check(common_offset, 2'h2, "offset");
      check({swing_a, swing_b}, 4'h6, "swings");
      check({deemph_a, deemph_b}, 4'hB, "deemphasis");
      check(extra_eq_gain, 1'h1, "eq gain");
      check(polarity_flip, 1'h1, "polarity");
      check({driver_a_off, driver_b_off}, 2'h3, "power down");
      rd(`OFS_EQ_DRIVER_COMMON, d);
      check(d, 8'h9B, "readback");
      sigPresent = 4'hA;
      cdrLock = 1'b1;
      tick(8);
      check(outASource, 2'h0, "reclocked");
      rd(`OFS_DETECT_LOCK_STATUS, d);
      check(d, 8'h1A, "status");
      wr(`OFS_DETECT_LOCK_STATUS, 8'h00);
      rd(`OFS_DETECT_LOCK_STATUS, d);
      check(d, 8'h1A, "status read only");
      rd(`OFS_ACTIVE_INPUT_STATUS, d);
      check(d[4], 1'h1, "active present");
      wr(`OFS_OUTPUT_SWING, 8'h66);
      check({locked_flag, outASource}, 3'h1, "register bypass");
      $display("test registers done");
   endtask

   task automatic t_override();
      logic [7:0] d;
      wr(`OFS_DETECT_LEVEL_CHAN, 8'h2E);
      check(detect_threshold, 3'h5, "threshold");
      check(activeChannel, 2'h1, "pins still pick");
      wr(`OFS_INPUT_OVERRIDE, 8'h80);
      check(activeChannel, 2'h3, "register choice");
      check(secondaryChannel, 2'h3, "secondary follows");
      wr(`OFS_SECONDARY_SELECT, 8'h02);
      wr(`OFS_SECONDARY_MUX, 8'h22);
      check({secondaryChannel, secondary_pre_post_eq}, 3'h5, "secondary own");
      wr(`OFS_EQ_DRIVER_COMMON, 8'h10);
      check({driver_a_off, driver_b_off}, 2'h2, "one driver off");
      wr(7'h05, 8'hFF);
      rd(7'h05, d);
      check(d, 8'h00, "unmapped");
      wr(`OFS_GENERAL_IO_ROLE, 8'h01);
      modeSelect = 1'b0;
      tick(10);
      check({registerMode, pinsAsGeneralIo}, 2'h1, "general io kept");
      $display("test override done");
   endtask

   initial begin
      tick(2);
      reset = 1'b0;
      t_reset();
      t_pick();
      t_outputs();
      t_regs();
      t_override();
      print_verdict();
   end
endmodule
